// ### hams_pkg.sv
package hams_pkg;
  // Operating mode codes from the two mode select bits.
  localparam logic [1:0] HAMS_MODE_AUTO  = 2'h0;
  localparam logic [1:0] HAMS_MODE_NAUTO = 2'h1;
  localparam logic [1:0] HAMS_MODE_TR0   = 2'h2;
  localparam logic [1:0] HAMS_MODE_TR1   = 2'h3;
  // Group addresses accepted in the high byte in every mode except transparent mode 0.
  localparam logic [7:0] HAMS_GRP_ADDR_A = 8'hFC;
  localparam logic [7:0] HAMS_GRP_ADDR_B = 8'hFE;
  // Control bytes of generated responses.
  localparam logic [7:0] HAMS_CTL_RR_RSP = 8'h11;
  localparam logic [7:0] HAMS_CTL_I_RSP  = 8'h10;
  // Field positions inside the control byte.
  localparam int HAMS_POLL_BIT = 4;
  // Command byte range bounds.
  localparam logic [3:0] HAMS_CMD_PREP_HI = 4'hA;
  localparam logic [3:0] HAMS_CMD_ACK_LO  = 4'hD;
  localparam logic [3:0] HAMS_CMD_ACK_HI  = 4'hE;
  // Fixed fields of the control response byte.
  localparam logic [1:0] HAMS_CRB_TOP     = 2'h2;
  localparam logic [1:0] HAMS_CRB_MID     = 2'h0;
  // Response kinds handed to the transmitter.
  typedef enum logic [3:0] {
    HAMS_RSP_NONE = 4'b0001,
    HAMS_RSP_RR   = 4'b0010,
    HAMS_RSP_CTL  = 4'b0100,
    HAMS_RSP_DATA = 4'b1000
  } hams_rsp_t;
  // Receive frame classes.
  typedef enum logic [3:0] {
    HAMS_FR_I    = 4'b0001,
    HAMS_FR_RR   = 4'b0010,
    HAMS_FR_EXT  = 4'b0100,
    HAMS_FR_NONE = 4'b1000
  } hams_frame_t;
endpackage : hams_pkg

// ### hams_rsp_if.sv
// Carries a response request from the frame decoder to the response builder.
interface hams_rsp_if;
  import hams_pkg::*;
  logic       req;       // One-cycle request for a response.
  hams_rsp_t  kind;      // Which response is wanted.
  logic [7:0] crb;       // Control response byte.
  modport src (output req, output kind, output crb);
  modport dst (input req, input kind, input crb);
endinterface : hams_rsp_if

// ### hams_tx_build.sv
// Emits the header bytes of a response frame one per cycle with ready_i set; the framer adds flags and CRC.
module hams_tx_build
  import hams_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       two_byte_i,  // Two-byte address in use.
  input  wire logic [7:0] addr1_i,     // Transmit address byte 1.
  input  wire logic [7:0] addr2_i,     // Transmit address byte 2.
  input  wire logic       ready_i,     // Framer takes a byte.
  hams_rsp_if.dst         rsp,
  output logic            valid_o,     // Byte on data_o is valid.
  output logic [7:0]      data_o,      // Header byte.
  output logic            last_o,      // Last generated byte.
  output logic            payload_o,   // Transmit FIFO data follows.
  output logic            busy_o       // Response in progress.
);
  logic [2:0] idx_q;   // Byte index within the header.
  logic [2:0] cnt_q;   // Number of header bytes.
  hams_rsp_t  kind_q;  // Latched response kind.
  logic [7:0] crb_q;   // Latched control response byte.
  logic [7:0] bytes [0:3];
  logic [2:0] a_off;   // Offset of the control byte.
  assign a_off    = two_byte_i ? 3'd2 : 3'd1;
  assign bytes[0] = addr1_i;
  assign bytes[1] = two_byte_i ? addr2_i : ((kind_q == HAMS_RSP_RR) ? HAMS_CTL_RR_RSP : HAMS_CTL_I_RSP);
  assign bytes[2] = two_byte_i ? ((kind_q == HAMS_RSP_RR) ? HAMS_CTL_RR_RSP : HAMS_CTL_I_RSP) : crb_q;
  assign bytes[3] = crb_q;
  assign data_o    = bytes[idx_q[1:0]];
  assign valid_o   = busy_o;
  assign last_o    = busy_o && (idx_q == cnt_q - 3'd1);
  assign payload_o = (kind_q == HAMS_RSP_DATA);

  // Latch a request and step through the header bytes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      idx_q  <= 3'd0;
      cnt_q  <= 3'd0;
      kind_q <= HAMS_RSP_NONE;
      crb_q  <= 8'h00;
    end else if (rsp.req && !busy_o) begin
      busy_o <= 1'b1;
      idx_q  <= 3'd0;
      kind_q <= rsp.kind;
      crb_q  <= rsp.crb;
      // Address, control, and the control response byte when asked.
      cnt_q  <= a_off + ((rsp.kind == HAMS_RSP_CTL) ? 3'd2 : 3'd1);
    end else if (busy_o && ready_i) begin
      if (last_o) begin
        busy_o <= 1'b0;
      end else begin
        idx_q <= idx_q + 3'd1;
      end
    end
  end
endmodule : hams_tx_build

// ### hams_top.sv
// Auto-mode secondary station frame handler: address filter, control decode,
// command byte interpretation and automatic response selection.
module hams_top
  import hams_pkg::*;
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       MODE_SELECT_HI_I,     // Upper mode select bit.
  input  wire logic       MODE_SELECT_LO_I,     // Lower mode select bit.
  input  wire logic       TWO_BYTE_ADDR_I,      // Two-byte address field.
  input  wire logic [7:0] LOW_ADDR_COMPARE_1_I,
  input  wire logic [7:0] LOW_ADDR_COMPARE_2_I,
  input  wire logic [7:0] HIGH_ADDR_COMPARE_1_I,
  input  wire logic [7:0] HIGH_ADDR_COMPARE_2_I,
  input  wire logic [7:0] TX_ADDR_BYTE_1_I,
  input  wire logic [7:0] TX_ADDR_BYTE_2_I,
  input  wire logic       AUTO_REPEAT_ENABLE_I,
  input  wire logic       TRANSMIT_DIRECT_CMD_I,   // Pulse: direct data loaded.
  input  wire logic       TRANSMIT_PREPARED_CMD_I, // Pulse: prepared data loaded.
  input  wire logic       RX_OVERFLOW_INDICATION_I,
  input  wire logic       RX_VALID_I,          // Received byte strobe.
  input  wire logic [7:0] RX_DATA_I,           // Received byte.
  input  wire logic       RX_END_I,            // Frame end pulse.
  input  wire logic       RX_CRC_ERR_I,        // With RX_END_I: bad CRC.
  input  wire logic       RX_ABORT_I,          // With RX_END_I: aborted.
  input  wire logic       TX_READY_I,          // Framer takes a header byte.
  output logic            RX_STORE_VALID_O,    // Byte to the receive FIFO.
  output logic [7:0]      RX_STORE_DATA_O,
  output logic            RX_STORE_END_O,      // Status byte follows.
  output logic [7:0]      RX_FRAME_STATUS_BYTE_O,
  output logic            RX_DROP_O,           // Discard bytes stored for this frame.
  output logic            EXTENDED_FRAME_IRQ_O,
  output logic [7:0]      RX_CONTROL_FIELD_HOLD_O,
  output logic            TX_POOL_READY_IRQ_O,
  output logic            TX_MESSAGE_REPEAT_IRQ_O,
  output logic            TX_FIFO_CLEAR_O,
  output logic            TX_VALID_O,
  output logic [7:0]      TX_DATA_O,
  output logic            TX_LAST_O,
  output logic            TX_PAYLOAD_O,        // Transmit FIFO data follows header.
  output logic            AUTO_MODE_O
);
  // Frame byte position, frame state.
  logic [2:0]  pos_q;          // Bytes seen, saturating.
  logic [7:0]  hi_q;           // First address byte.
  logic [7:0]  ctl_q;          // Control byte.
  logic [7:0]  cmd_q;          // First data byte.
  logic        have_cmd_q;     // A command byte was received.
  logic        proto_q;        // Address selects auto protocol.
  logic        match_q;        // Any valid address match.
  logic        direct_q;       // Direct data loaded, unacknowledged.
  logic        prepared_q;     // Prepared data loaded.
  logic        sent_q;         // A data frame has gone out.
  hams_rsp_if  rsp ();
  logic        rsp_req_q;
  hams_rsp_t   rsp_kind_q;
  logic        tx_busy;
  logic        tx_valid, tx_last, tx_pay;
  logic [7:0]  tx_data;

  // Mode decode.
  wire logic [1:0] mode     = {MODE_SELECT_HI_I, MODE_SELECT_LO_I};
  wire logic       auto_m   = (mode == HAMS_MODE_AUTO);
  wire logic       two_b    = TWO_BYTE_ADDR_I && (mode != HAMS_MODE_TR1);
  wire logic [2:0] a_len    = two_b ? 3'd2 : 3'd1;
  wire logic       in_addr  = RX_VALID_I && (pos_q < a_len);
  wire logic       last_a   = RX_VALID_I && (pos_q == a_len - 3'd1);
  wire logic       in_ctl   = RX_VALID_I && (pos_q == a_len);
  wire logic       in_cmd   = RX_VALID_I && (pos_q == a_len + 3'd1);

  // Address comparison on the final address byte.
  wire logic [7:0] hb      = two_b ? hi_q : RX_DATA_I;
  wire logic       hi_1    = (hb == HIGH_ADDR_COMPARE_1_I);
  wire logic       hi_oth  = (hb == HIGH_ADDR_COMPARE_2_I) || (hb == HAMS_GRP_ADDR_A) ||
                             (hb == HAMS_GRP_ADDR_B);
  wire logic       lo_1    = (RX_DATA_I == LOW_ADDR_COMPARE_1_I);
  wire logic       lo_2    = (RX_DATA_I == LOW_ADDR_COMPARE_2_I);
  wire logic       lo_any  = lo_1 || lo_2;
  wire logic       hi_any  = hi_1 || hi_oth;
  // Transparent mode 1 checks the high byte alone.
  wire logic       m_tr1   = (mode == HAMS_MODE_TR1) && hi_any;
  wire logic       m_two   = two_b && hi_any && lo_any;
  wire logic       m_one   = !two_b && (mode != HAMS_MODE_TR1) && lo_any;
  wire logic       m_any   = (mode != HAMS_MODE_TR0) && (m_tr1 || m_two || m_one);
  wire logic       m_prot  = auto_m && lo_1 && (!two_b || hi_1);

  // Control byte classification.
  wire logic       poll    = ctl_q[HAMS_POLL_BIT];
  wire hams_frame_t fcls   = !ctl_q[0] ? HAMS_FR_I :
                             (ctl_q[1:0] == 2'b01) ? HAMS_FR_RR : HAMS_FR_EXT;
  wire logic [3:0] cmd_hi  = cmd_q[7:4];
  wire logic       cmd_prep = have_cmd_q && (cmd_hi == HAMS_CMD_PREP_HI);
  wire logic       cmd_ack  = have_cmd_q && (cmd_hi >= HAMS_CMD_ACK_LO) &&
                              (cmd_hi <= HAMS_CMD_ACK_HI);
  wire logic       cmd_store = !cmd_prep && !cmd_ack;
  wire logic       bad_end   = RX_CRC_ERR_I || RX_ABORT_I;
  wire logic       prot_ok   = proto_q && match_q;
  // Frames stored: matches not under protocol control, and protocol I-frames that are ordinary or damaged.
  wire logic       store_fr  = match_q && (!proto_q ||
                               (fcls == HAMS_FR_I && (cmd_store || bad_end)));
  // Control response byte; with no DMA path here its layout never changes.
  wire logic [7:0] crb = {HAMS_CRB_TOP, 1'b1, AUTO_REPEAT_ENABLE_I, HAMS_CRB_MID,
                          !RX_OVERFLOW_INDICATION_I, 1'b1};
  // Decision on a frame end under protocol control; all but ext_fr need a good end.
  wire logic       ev_end   = RX_END_I && prot_ok && !bad_end;
  wire logic       ev_rr    = ev_end && (fcls == HAMS_FR_RR);
  wire logic       ev_i     = ev_end && (fcls == HAMS_FR_I);
  wire logic       rr_poll  = ev_rr && poll;
  wire logic       rr_ack   = ev_rr && !poll;
  wire logic       i_poll   = ev_i && poll;
  wire logic       ext_fr   = RX_END_I && prot_ok && (fcls == HAMS_FR_EXT);
  wire logic       repoll   = sent_q && ((rr_poll && direct_q) || (i_poll && cmd_prep && prepared_q));
  wire logic       ack_prep = ev_i && cmd_ack && prepared_q;
  // Response selection; only polls start one.
  wire hams_rsp_t  sel_kind = rr_poll ? (direct_q ? HAMS_RSP_DATA : HAMS_RSP_RR) :
                              (cmd_prep && prepared_q) ? HAMS_RSP_DATA :
                              HAMS_RSP_CTL;
  wire logic       want_rsp = (rr_poll || i_poll) && !tx_busy;

  assign rsp.req  = rsp_req_q;
  assign rsp.kind = rsp_kind_q;
  assign rsp.crb  = crb;

  hams_tx_build u_tx (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RESETN_I),
    .two_byte_i (TWO_BYTE_ADDR_I),
    .addr1_i    (TX_ADDR_BYTE_1_I),
    .addr2_i    (TX_ADDR_BYTE_2_I),
    .ready_i    (TX_READY_I),
    .rsp        (rsp.dst),
    .valid_o    (tx_valid),
    .data_o     (tx_data),
    .last_o     (tx_last),
    .payload_o  (tx_pay),
    .busy_o     (tx_busy)
  );

  // Frame position and header capture.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pos_q      <= 3'd0;
      hi_q       <= 8'h00;
      ctl_q      <= 8'h00;
      cmd_q      <= 8'h00;
      have_cmd_q <= 1'b0;
      proto_q    <= 1'b0;
      match_q    <= 1'b0;
    end else if (RX_END_I) begin
      pos_q      <= 3'd0;  // Next frame starts fresh.
      have_cmd_q <= 1'b0;
      match_q    <= 1'b0;
      proto_q    <= 1'b0;
    end else if (RX_VALID_I) begin
      if (pos_q != 3'd7) begin
        pos_q <= pos_q + 3'd1;
      end
      if (in_addr && !last_a) begin
        hi_q <= RX_DATA_I;
      end
      if (last_a) begin
        match_q <= m_any || m_prot;
        proto_q <= m_prot;
      end
      if (in_ctl) begin
        ctl_q <= RX_DATA_I;
      end
      if (in_cmd) begin
        cmd_q      <= RX_DATA_I;
        have_cmd_q <= 1'b1;
      end
    end
  end

  // Receive store path: bytes flow once the address matched. Protocol frames
  // that turn out not to be stored are dropped by RX_DROP_O at frame end.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RX_STORE_VALID_O       <= 1'b0;
      RX_STORE_DATA_O        <= 8'h00;
      RX_STORE_END_O         <= 1'b0;
      RX_FRAME_STATUS_BYTE_O <= 8'h00;
      RX_DROP_O              <= 1'b0;
    end else begin
      RX_STORE_VALID_O <= RX_VALID_I && !in_addr && match_q && !(proto_q && fcls != HAMS_FR_I && !in_ctl);
      RX_STORE_DATA_O  <= RX_DATA_I;
      RX_STORE_END_O   <= RX_END_I && store_fr;
      RX_DROP_O        <= RX_END_I && match_q && !store_fr;
      if (RX_END_I) begin
        RX_FRAME_STATUS_BYTE_O <= {RX_CRC_ERR_I, RX_ABORT_I, 6'h00};
      end
    end
  end

  // Transmit data state: window of one outstanding frame.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      direct_q   <= 1'b0;
      prepared_q <= 1'b0;
      sent_q     <= 1'b0;
    end else begin
      if (rr_ack || ack_prep) begin
        direct_q   <= 1'b0;
        prepared_q <= 1'b0;
        sent_q     <= 1'b0;
      end else if (want_rsp && sel_kind == HAMS_RSP_DATA) begin
        sent_q <= 1'b1;
      end
      // A new load wins over an acknowledge in the same cycle.
      if (TRANSMIT_DIRECT_CMD_I) begin
        direct_q <= 1'b1;
      end
      if (TRANSMIT_PREPARED_CMD_I) begin
        prepared_q <= 1'b1;
      end
    end
  end

  // Response request and events toward the CPU.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rsp_req_q               <= 1'b0;
      rsp_kind_q              <= HAMS_RSP_NONE;
      EXTENDED_FRAME_IRQ_O    <= 1'b0;
      RX_CONTROL_FIELD_HOLD_O <= 8'h00;
      TX_POOL_READY_IRQ_O     <= 1'b0;
      TX_MESSAGE_REPEAT_IRQ_O <= 1'b0;
      TX_FIFO_CLEAR_O         <= 1'b0;
      AUTO_MODE_O             <= 1'b0;
    end else begin
      rsp_req_q  <= want_rsp;
      rsp_kind_q <= sel_kind;
      AUTO_MODE_O <= auto_m;
      EXTENDED_FRAME_IRQ_O <= ext_fr;
      if (ext_fr) begin
        RX_CONTROL_FIELD_HOLD_O <= ctl_q;
      end
      TX_POOL_READY_IRQ_O <= rr_ack || ack_prep;
      TX_FIFO_CLEAR_O     <= rr_ack || ack_prep;
      // A repeated poll without auto repeat asks the CPU to reload.
      TX_MESSAGE_REPEAT_IRQ_O <= repoll && !AUTO_REPEAT_ENABLE_I;
    end
  end

  // Header bytes to the framer.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_VALID_O   <= 1'b0;
      TX_DATA_O    <= 8'h00;
      TX_LAST_O    <= 1'b0;
      TX_PAYLOAD_O <= 1'b0;
    end else begin
      TX_VALID_O   <= tx_valid && TX_READY_I;
      TX_DATA_O    <= tx_data;
      TX_LAST_O    <= tx_last && TX_READY_I;
      TX_PAYLOAD_O <= tx_pay && tx_last && TX_READY_I;
    end
  end
endmodule : hams_top

// ### hams_check_properties.sv
// Watches the frame handler's ports and flags breaks of its mode, header byte, status byte, extended frame and damaged-frame response rules.
module hams_check_properties
  import hams_pkg::*;
(
  input wire logic       SYS_CLK_I, RESETN_I, MODE_SELECT_HI_I, MODE_SELECT_LO_I,
  input wire logic       AUTO_REPEAT_ENABLE_I, RX_OVERFLOW_INDICATION_I, RX_END_I,
  input wire logic       RX_CRC_ERR_I, RX_ABORT_I, TX_READY_I, RX_STORE_END_O,
  input wire logic       EXTENDED_FRAME_IRQ_O, TX_VALID_O, TX_LAST_O, TX_PAYLOAD_O,
  input wire logic       AUTO_MODE_O,
  input wire logic [7:0] RX_FRAME_STATUS_BYTE_O, RX_CONTROL_FIELD_HOLD_O, TX_DATA_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [5:0] since_end_q; // Cycles since the last frame end; saturates on an idle link.
  logic [5:0] since_end_d; // Next value of the frame end distance.
  assign since_end_d = RX_END_I ? 6'h00 : since_end_q + {5'h00, since_end_q != 6'h3F};
  // Tracks how long ago a frame ended, so a response can be tied to a frame.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      since_end_q <= 6'h3F;
    end else begin
      since_end_q <= since_end_d;
    end
  end
  a_auto_mode_sel: assert property ((!MODE_SELECT_HI_I && !MODE_SELECT_LO_I) [*2] |-> AUTO_MODE_O)
    else $error("auto mode not shown for mode select 00");
  a_no_spont_tx: assert property ($rose(TX_VALID_O) |-> since_end_q < 6'h28)
    else $error("response byte without a preceding frame");
  a_tx_handshake: assert property (TX_VALID_O |-> $past(TX_READY_I))
    else $error("header byte sent without framer ready");
  a_payload_ctl: assert property (TX_PAYLOAD_O |-> TX_VALID_O && TX_LAST_O && TX_DATA_O == 8'h10)
    else $error("data frame header does not end in control 10");
  a_last_byte: assert property (TX_VALID_O && TX_LAST_O && !TX_PAYLOAD_O |->
      TX_DATA_O == 8'h11 || {TX_DATA_O[7:5], TX_DATA_O[3:2], TX_DATA_O[0]} == 6'h29)
    else $error("response ends in neither 11 nor a control response byte");
  a_crb_fields: assert property (TX_VALID_O && TX_LAST_O && !TX_PAYLOAD_O &&
      TX_DATA_O[7:5] == 3'h5 |-> TX_DATA_O[4] == AUTO_REPEAT_ENABLE_I &&
      TX_DATA_O[1] == !RX_OVERFLOW_INDICATION_I)
    else $error("control response byte repeat or overflow bit wrong");
  a_ext_hold: assert property (EXTENDED_FRAME_IRQ_O |=>
      RX_CONTROL_FIELD_HOLD_O[1:0] == 2'h3 && !EXTENDED_FRAME_IRQ_O)
    else $error("extended frame hold register or pulse wrong");
  a_ext_no_store: assert property (EXTENDED_FRAME_IRQ_O |-> !RX_STORE_END_O)
    else $error("extended frame kept in receive storage");
  a_status_flags: assert property (RX_STORE_END_O |->
      RX_FRAME_STATUS_BYTE_O[7:6] == $past({RX_CRC_ERR_I, RX_ABORT_I}))
    else $error("status byte error flags wrong");
  a_bad_no_rsp: assert property (RX_END_I && (RX_CRC_ERR_I || RX_ABORT_I) |=> !TX_VALID_O [*6])
    else $error("response sent to a damaged frame");
endmodule : hams_check_properties

// ### hams_framer_model.sv
// Framer beside the handler: takes header bytes at once or stalls two cycles of three.
module hams_framer_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic slow_i,   // Selects the stalling pattern.
  output logic      ready_o   // Framer takes a header byte.
);
  logic [1:0] phase_q; // Position in the stall pattern.
  logic [1:0] phase_d; // Next position.
  assign phase_d = (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
  assign ready_o = !slow_i || (phase_q == 2'h0);
  // Steps the stall pattern every cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end
endmodule : hams_framer_model

// ### hdlc_auto_mode_secondary_tb.sv
// Bench for the frame handler: frames go in byte by byte, events are counted per frame.
module hdlc_auto_mode_secondary_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       SYS_CLK_I, RESETN_I, MODE_SELECT_HI_I, MODE_SELECT_LO_I, TWO_BYTE_ADDR_I;
  logic [7:0] LOW_ADDR_COMPARE_1_I, LOW_ADDR_COMPARE_2_I, HIGH_ADDR_COMPARE_1_I;
  logic [7:0] HIGH_ADDR_COMPARE_2_I, TX_ADDR_BYTE_1_I, TX_ADDR_BYTE_2_I, RX_DATA_I;
  logic       AUTO_REPEAT_ENABLE_I, TRANSMIT_DIRECT_CMD_I, TRANSMIT_PREPARED_CMD_I;
  logic       RX_OVERFLOW_INDICATION_I, RX_VALID_I, RX_END_I, RX_CRC_ERR_I, RX_ABORT_I;
  logic       TX_READY_I, RX_STORE_VALID_O, RX_STORE_END_O, RX_DROP_O, EXTENDED_FRAME_IRQ_O;
  logic       TX_POOL_READY_IRQ_O, TX_MESSAGE_REPEAT_IRQ_O, TX_FIFO_CLEAR_O, TX_VALID_O;
  logic       TX_LAST_O, TX_PAYLOAD_O, AUTO_MODE_O, slow;
  logic [7:0] RX_STORE_DATA_O, RX_FRAME_STATUS_BYTE_O, RX_CONTROL_FIELD_HOLD_O, TX_DATA_O;
  logic [7:0] cnt [9];          // Keep, ext, pool, clear, repeat, tx, payload, drop, store.
  logic [7:0] last_tx, last_sts, last_rx; // Last header, status and stored byte.
  logic [8:0] ev;               // Event strobes in counter order.
  logic [7:0] cmds [6] = '{8'h00, 8'h9F, 8'hB0, 8'hCF, 8'hF0, 8'hFF}; // Stored command edges.
  int         mismatches, checks_done;
  hams_top DUT (.SYS_CLK_I, .RESETN_I, .MODE_SELECT_HI_I, .MODE_SELECT_LO_I, .TWO_BYTE_ADDR_I,
    .LOW_ADDR_COMPARE_1_I, .LOW_ADDR_COMPARE_2_I, .HIGH_ADDR_COMPARE_1_I,
    .HIGH_ADDR_COMPARE_2_I, .TX_ADDR_BYTE_1_I, .TX_ADDR_BYTE_2_I, .AUTO_REPEAT_ENABLE_I,
    .TRANSMIT_DIRECT_CMD_I, .TRANSMIT_PREPARED_CMD_I, .RX_OVERFLOW_INDICATION_I, .RX_VALID_I,
    .RX_DATA_I, .RX_END_I, .RX_CRC_ERR_I, .RX_ABORT_I, .TX_READY_I, .RX_STORE_VALID_O,
    .RX_STORE_DATA_O, .RX_STORE_END_O, .RX_FRAME_STATUS_BYTE_O, .RX_DROP_O,
    .EXTENDED_FRAME_IRQ_O, .RX_CONTROL_FIELD_HOLD_O, .TX_POOL_READY_IRQ_O,
    .TX_MESSAGE_REPEAT_IRQ_O, .TX_FIFO_CLEAR_O, .TX_VALID_O, .TX_DATA_O, .TX_LAST_O,
    .TX_PAYLOAD_O, .AUTO_MODE_O);
  hams_framer_model u_framer (.clk_i(SYS_CLK_I), .rst_n_i(RESETN_I), .slow_i(slow),
    .ready_o(TX_READY_I));
  assign ev = {RX_STORE_VALID_O, RX_DROP_O, TX_PAYLOAD_O, TX_VALID_O,
               TX_MESSAGE_REPEAT_IRQ_O, TX_FIFO_CLEAR_O,
               TX_POOL_READY_IRQ_O, EXTENDED_FRAME_IRQ_O, RX_STORE_END_O};
  always #5 SYS_CLK_I = ~SYS_CLK_I;
  // Counts event pulses and keeps the last header byte and status byte.
  always @(posedge SYS_CLK_I) begin
    for (int i = 0; i < 9; i++) begin
      if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 8'h01;
    end
    if (TX_VALID_O === 1'b1) last_tx <= TX_DATA_O;
    if (RX_STORE_END_O === 1'b1) last_sts <= RX_FRAME_STATUS_BYTE_O;
    if (RX_STORE_VALID_O === 1'b1) last_rx <= RX_STORE_DATA_O;
  end
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Drives one received byte; the strobe stays up for the next byte.
  task automatic put(input logic [7:0] b);
    RX_DATA_I = b;
    RX_VALID_I = 1'b1;
    @(posedge SYS_CLK_I);
    #1;
  endtask : put
  // Issues a one-cycle transmit command: prepared when prep is set, direct otherwise.
  task automatic cmd_pulse(input logic prep);
    TRANSMIT_PREPARED_CMD_I = prep;
    TRANSMIT_DIRECT_CMD_I = !prep;
    @(posedge SYS_CLK_I);
    #1;
    {TRANSMIT_PREPARED_CMD_I, TRANSMIT_DIRECT_CMD_I} = 2'b00;
  endtask : cmd_pulse
  // Sends address bytes as the mode wants, control, command for I-frames, then the end.
  task automatic frame(input logic [7:0] hi, lo, ctl, cmd, input logic [1:0] err);
    for (int i = 0; i < 9; i++) cnt[i] = 8'h00;
    if (TWO_BYTE_ADDR_I || (MODE_SELECT_HI_I && MODE_SELECT_LO_I)) put(hi);
    if (!(MODE_SELECT_HI_I && MODE_SELECT_LO_I)) put(lo);
    put(ctl);
    if (!ctl[0]) put(cmd);
    RX_VALID_I = 1'b0;
    RX_END_I = 1'b1;
    {RX_CRC_ERR_I, RX_ABORT_I} = err;
    @(posedge SYS_CLK_I);
    #1;
    RX_END_I = 1'b0;
    {RX_CRC_ERR_I, RX_ABORT_I} = 2'b00;
    repeat (20) @(posedge SYS_CLK_I);
    #1;
  endtask : frame
  // Compares the counted events; a tx count of FF skips the transmit side.
  task automatic exp_ev(input logic [7:0] k, e, p, m, t, pl, lb);
    chk(cnt[0], k);
    chk(cnt[1], e);
    chk(cnt[2], p);
    chk(cnt[3], p);
    chk(cnt[4], m);
    if (t !== 8'hFF) begin
      chk(cnt[5], t);
      chk(cnt[6], pl);
      if (t !== 8'h00) chk(last_tx, lb);
    end
  endtask : exp_ev
  initial begin
    #50us;
    mismatches++;
    end_of_test;
  end
  // Main sequence: auto mode one-byte, prepared and direct data, two-byte, other modes.
  initial begin
    {SYS_CLK_I, RESETN_I, MODE_SELECT_HI_I, MODE_SELECT_LO_I, TWO_BYTE_ADDR_I} = 5'h00;
    {AUTO_REPEAT_ENABLE_I, TRANSMIT_DIRECT_CMD_I, TRANSMIT_PREPARED_CMD_I} = 3'h0;
    {RX_OVERFLOW_INDICATION_I, RX_VALID_I, RX_END_I, RX_CRC_ERR_I, RX_ABORT_I, slow} = 6'h00;
    {LOW_ADDR_COMPARE_1_I, LOW_ADDR_COMPARE_2_I, RX_DATA_I} = {8'h21, 8'h22, 8'h00};
    {HIGH_ADDR_COMPARE_1_I, HIGH_ADDR_COMPARE_2_I} = {8'h40, 8'h41};
    {TX_ADDR_BYTE_1_I, TX_ADDR_BYTE_2_I} = {8'h5A, 8'h5B};
    repeat (3) @(posedge SYS_CLK_I);
    #1;
    RESETN_I = 1'b1;
    @(posedge SYS_CLK_I);
    #1;
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 2, 0, 8'h11);
    chk(cnt[7], 8'h01);
    chk({7'h00, AUTO_MODE_O}, 8'h01);
    frame(8'h00, 8'h33, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 0, 0, 0);
    frame(8'h00, 8'h22, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    chk(cnt[7], 8'h00);
    frame(8'h00, 8'h21, 8'h13, 8'h00, 2'b00); exp_ev(0, 1, 0, 0, 0, 0, 0);
    chk(RX_CONTROL_FIELD_HOLD_O, 8'h13);
    foreach (cmds[i]) begin
      frame(8'h00, 8'h21, 8'h10, cmds[i], 2'b00); exp_ev(1, 0, 0, 0, 3, 0, 8'hA3);
    end
    frame(8'h00, 8'h21, 8'h10, 8'hA5, 2'b00); exp_ev(0, 0, 0, 0, 3, 0, 8'hA3);
    frame(8'h00, 8'h21, 8'h00, 8'h10, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    chk(cnt[8], 8'h02);
    chk(last_rx, 8'h10);
    frame(8'h00, 8'h21, 8'h10, 8'h10, 2'b10); exp_ev(1, 0, 0, 0, 0, 0, 0);
    chk(last_sts & 8'hC0, 8'h80);
    frame(8'h00, 8'h21, 8'h10, 8'h10, 2'b01); exp_ev(1, 0, 0, 0, 0, 0, 0);
    chk(last_sts & 8'hC0, 8'h40);
    frame(8'h00, 8'h21, 8'h10, 8'hEF, 2'b00); exp_ev(0, 0, 0, 0, 3, 0, 8'hA3);
    cmd_pulse(1'b1);
    frame(8'h00, 8'h21, 8'h10, 8'hA0, 2'b00); exp_ev(0, 0, 0, 0, 2, 1, 8'h10);
    frame(8'h00, 8'h21, 8'h00, 8'hD0, 2'b00); exp_ev(0, 0, 1, 0, 0, 0, 0);
    cmd_pulse(1'b0);
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 2, 1, 8'h10);
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 1, 8'hFF, 0, 0);
    frame(8'h00, 8'h21, 8'h01, 8'h00, 2'b00); exp_ev(0, 0, 1, 0, 0, 0, 0);
    AUTO_REPEAT_ENABLE_I = 1'b1;
    cmd_pulse(1'b0);
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 2, 1, 8'h10);
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 2, 1, 8'h10);
    RX_OVERFLOW_INDICATION_I = 1'b1;
    frame(8'h00, 8'h21, 8'h10, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 3, 0, 8'hB1);
    frame(8'h00, 8'h21, 8'h01, 8'h00, 2'b00); exp_ev(0, 0, 1, 0, 0, 0, 0);
    {AUTO_REPEAT_ENABLE_I, RX_OVERFLOW_INDICATION_I, TWO_BYTE_ADDR_I, slow} = 4'h3;
    TX_ADDR_BYTE_1_I = 8'h6C;
    frame(8'h40, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 3, 0, 8'h11);
    frame(8'hFC, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    frame(8'h40, 8'h22, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    {TWO_BYTE_ADDR_I, slow, MODE_SELECT_LO_I} = 3'h1;
    frame(8'h00, 8'h21, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    chk({7'h00, AUTO_MODE_O}, 8'h00);
    MODE_SELECT_HI_I = 1'b1;
    frame(8'hFE, 8'h00, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    frame(8'h41, 8'h00, 8'h11, 8'h00, 2'b00); exp_ev(1, 0, 0, 0, 0, 0, 0);
    frame(8'h77, 8'h00, 8'h11, 8'h00, 2'b00); exp_ev(0, 0, 0, 0, 0, 0, 0);
    end_of_test;
  end
endmodule : hdlc_auto_mode_secondary_tb
bind hams_top hams_check_properties u_chk (.SYS_CLK_I, .RESETN_I, .MODE_SELECT_HI_I,
  .MODE_SELECT_LO_I, .AUTO_REPEAT_ENABLE_I, .RX_OVERFLOW_INDICATION_I, .RX_END_I,
  .RX_CRC_ERR_I, .RX_ABORT_I, .TX_READY_I, .RX_STORE_END_O, .EXTENDED_FRAME_IRQ_O,
  .TX_VALID_O, .TX_LAST_O, .TX_PAYLOAD_O, .AUTO_MODE_O, .RX_FRAME_STATUS_BYTE_O,
  .RX_CONTROL_FIELD_HOLD_O, .TX_DATA_O);
